// ---- keypad_pins.sv ----
// Far side of the ports: keypad switches, pull-ups, outside driver.
// Assumes a pressed key shorts its line harder than any pin drive.
`timescale 1ns/10ps
module keypad_pins (
   // Clock
   input  wire logic       core_clk,
   // Second port
   input  wire logic [7:0] secondPortOut,
   input  wire logic [7:0] secondPortOe_n,
   input  wire logic [7:0] secondPullupEn,
   input  wire logic [7:0] keyDown,
   output logic      [7:0] secondPortIn,
   // Third port
   input  wire logic [7:0] thirdPortOut,
   input  wire logic [7:0] thirdPortOe_n,
   input  wire logic [7:0] thirdFar,
   output logic      [7:0] thirdPortIn
);
   // ------------------------------------------------------------
   // Line levels
   // ------------------------------------------------------------
   logic toggle;
   // A line with nothing on it wanders, so never trust its last value
   always_ff @(posedge core_clk) toggle <= (toggle === 1'b1) ? 1'b0 : 1'b1;
   // Key wins, then the pin drive, then the pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (keyDown[i]) secondPortIn[i] = 1'b0;
         else if (!secondPortOe_n[i]) secondPortIn[i] = secondPortOut[i];
         else if (secondPullupEn[i]) secondPortIn[i] = 1'b1;
         else secondPortIn[i] = toggle;
      end
   end
   // Released third port lines are held by the outside device
   assign thirdPortIn = (thirdPortOut & ~thirdPortOe_n) |
                        (thirdFar & thirdPortOe_n);
endmodule : keypad_pins

// ---- keypad_port_assertions.sv ----
// Concurrent checks on the keypad port: bus timing, pins, interrupt.
// Assumes one clock domain; bound to the top module after endmodule.
`timescale 1ns/10ps
module keypad_port_checker (
   // Clock, reset and bus
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        wbStb,
   input wire logic        wbWe,
   input wire logic [31:0] wbDatOut,
   input wire logic        wbAck,
   // Pins
   input wire logic [1:0]  busMode,
   input wire logic [1:0]  firstOdOe_n,
   input wire logic [7:0]  secondPortIn,
   input wire logic [7:0]  secondPortOut,
   input wire logic [7:0]  secondPortOe_n,
   input wire logic [7:0]  secondPullupEn,
   input wire logic        capture_in_a,
   input wire logic        capture_in_b,
   input wire logic        timer_ab_ext_clock,
   input wire logic        timer_c_ext_clock,
   input wire logic        spiClkIn,
   input wire logic        pwm_out_a,
   input wire logic        pwmOnA,
   input wire logic [7:0]  thirdPortIn,
   input wire logic [7:0]  thirdPortOut,
   input wire logic [7:0]  thirdPortOe_n,
   input wire logic [7:0]  busAdOut,
   input wire logic        busAdDrive,
   input wire logic [7:0]  bus_addr_data_low,
   // Interrupt
   input wire logic        irq,
   input wire logic        wakeRequest
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   AST_ACK_PULSE: assert property (wbAck |=> !wbAck)
      else $error("ack held longer than one cycle");
   AST_ACK_LATE: assert property ($rose(wbStb) |=> wbAck)
      else $error("ack not one cycle after request");
   AST_READ_HIGH: assert property (wbAck && !wbWe |->
      wbDatOut[31:8] == 24'h0) else $error("read data upper not zero");
   AST_PULLUP_OUT: assert property (
      (secondPullupEn & ~secondPortOe_n) == 8'h00)
      else $error("pull-up on an output pin");
   // Values are still the reset ones at the first edge after release
   AST_RST_STATE: assert property ($fell(reset) |->
      firstOdOe_n == 2'h3 && secondPullupEn == 8'hFF &&
      (busMode < 2'h2 || thirdPortOe_n == 8'hFF))
      else $error("pin state wrong after reset");
   AST_IRQ_STICKY: assert property (irq && !(wbStb && wbWe) |=> irq)
      else $error("interrupt dropped without a write");
   AST_WAKE: assert property (wakeRequest == irq)
      else $error("wake request differs from interrupt");
   AST_BUS_MODE: assert property (busMode < 2'h2 |->
      bus_addr_data_low == thirdPortIn && (!busAdDrive ||
      thirdPortOut == busAdOut && thirdPortOe_n == 8'h00))
      else $error("third port not acting as bus");
   AST_SYNC: assert property (!$past(reset, 2) && !$past(reset) |->
      capture_in_a == $past(secondPortIn[0], 2) &&
      capture_in_b == $past(secondPortIn[1], 2) &&
      timer_ab_ext_clock == $past(secondPortIn[4], 2) &&
      timer_c_ext_clock == $past(secondPortIn[5], 2) &&
      spiClkIn == $past(secondPortIn[6], 2))
      else $error("synchronised pin late or wrong");
   AST_PWM_DRIVE: assert property (pwmOnA |-> !secondPortOe_n[2] &&
      secondPortOut[2] == pwm_out_a) else $error("pwm not on pin");
   cover property ($rose(irq));
   cover property (busMode < 2'h2 && busAdDrive);
   cover property (wbAck && wbWe);
endmodule : keypad_port_checker

bind keypad_port_with_change_irq keypad_port_checker u_chk (
   .core_clk, .reset, .wbStb, .wbWe, .wbDatOut, .wbAck, .busMode,
   .firstOdOe_n, .secondPortIn, .secondPortOut, .secondPortOe_n,
   .secondPullupEn, .capture_in_a, .spiClkIn, .pwm_out_a, .pwmOnA,
   .capture_in_b, .timer_ab_ext_clock, .timer_c_ext_clock,
   .thirdPortIn, .thirdPortOut, .thirdPortOe_n, .busAdOut, .busAdDrive,
   .bus_addr_data_low, .irq, .wakeRequest);

// ---- keypad_port_pkg.sv ----
// Constants for the keypad port block: register indices, field
// positions, reset values and the bus states.
// Assumes a Wishbone slave with 32-bit data and byte addressing.
package keypad_port_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_FIRST_PORT   = 8'h10;
   localparam logic [7:0] IDX_SECOND_DIR   = 8'h11;
   localparam logic [7:0] IDX_SECOND_DATA  = 8'h12;
   localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h16;
   localparam logic [7:0] IDX_PERIPH_ENAB  = 8'h17;
   localparam logic [7:0] IDX_THIRD_DIR    = 8'h18;
   localparam logic [7:0] IDX_THIRD_DATA   = 8'h19;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PULLUP_BIT      = 7;
   localparam int CHANGE_FLAG_BIT = 7;
   localparam int CHANGE_IE_BIT   = 7;
   localparam int OD_LO_BIT       = 2;
   localparam int OD_HI_BIT       = 3;
   localparam int CAP_A_BIT       = 0;
   localparam int CAP_B_BIT       = 1;
   localparam int PWM_A_BIT       = 2;
   localparam int PWM_B_BIT       = 3;
   localparam int TCLK_AB_BIT     = 4;
   localparam int TCLK_C_BIT      = 5;
   localparam int SPI_CLK_BIT     = 6;
   localparam int SPI_DATA_BIT    = 7;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic       PULLUP_RST   = 1'b0;
   localparam logic [1:0] OD_LATCH_RST = 2'h3;
   localparam logic [7:0] DIR_RST      = 8'hFF;
   localparam logic [7:0] LATCH_RST    = 8'h00;
   localparam logic       FLAG_RST     = 1'b0;
   localparam logic       ENABLE_RST   = 1'b0;

   // ----------------------------------------------------------------
   // Configuration modes and bus states
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_MICROPROC = 2'h0;
   localparam logic [1:0] MODE_EXT_MCU   = 2'h1;
   localparam logic [1:0] MODE_MCU       = 2'h2;
   localparam logic [1:0] MODE_PROT_MCU  = 2'h3;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_t;

endpackage : keypad_port_pkg

// ---- keypad_port_with_change_irq.sv ----
// Eight-bit keypad port with change interrupt and shared pull-ups,
// a multiplexed address/data port and the pull-up control bit.
// Assumes classic Wishbone with 32-bit data, first and third port pins
// already synchronous to core_clk, and a pad ring that resolves the enables.
//
// How it works
// - Direction bit one is input, zero output
// - Data reads give pins, writes load latch
// - Clearing the shared bit enables all pull-ups
// - Output pins never get a pull-up
// - Reset clears pull-up bit; first port pattern
// - Input pins versus latch mismatches set flag
// - Mismatch keeps flag set; software clears later
// - Change interrupt can wake from sleep
// - Flag after reset follows pins and latch
// - Second port pins carry alternate functions
// - First port pins are inputs after reset
// - Third port like second: pins read, latch written
// - Bus modes turn third port into address/data
// - Reset forces every direction bit to one
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps
module keypad_port_with_change_irq
   import keypad_port_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Wishbone slave
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [11:0] wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatIn,
   output logic      [31:0] wbDatOut,
   output logic             wbAck,
   // Device configuration
   input  wire logic [1:0]  busMode,
   // First port pins
   input  wire logic [5:0]  firstPortIn,
   output logic      [1:0]  firstOdOe_n,
   // Second port pins
   input  wire logic [7:0]  secondPortIn,
   output logic      [7:0]  secondPortOut,
   output logic      [7:0]  secondPortOe_n,
   output logic      [7:0]  secondPullupEn,
   // Second port alternate functions
   output logic             capture_in_a,
   output logic             capture_in_b,
   input  wire logic        pwm_out_a,
   input  wire logic        pwmOnA,
   input  wire logic        pwm_out_b,
   input  wire logic        pwmOnB,
   output logic             timer_ab_ext_clock,
   output logic             timer_c_ext_clock,
   input  wire logic        spiClkOut,
   input  wire logic        spiClkDrive,
   output logic             spiClkIn,
   input  wire logic        spiDataOut,
   input  wire logic        spiDataDrive,
   // Third port pins
   input  wire logic [7:0]  thirdPortIn,
   output logic      [7:0]  thirdPortOut,
   output logic      [7:0]  thirdPortOe_n,
   // External bus side of the third port
   input  wire logic [7:0]  busAdOut,
   input  wire logic        busAdDrive,
   output logic      [7:0]  bus_addr_data_low,
   // Interrupt and wake
   output logic             irq,
   output logic             wakeRequest
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   bus_state_t busState;
   bus_state_t next_busState;
   logic [7:0] regIdx;
   logic       accessReq;
   logic       writeReq;
   logic       readReq;
   logic       lane0;
   logic       pullup_disable_n;
   logic [1:0] firstOdLatch;
   logic [7:0] second_port_direction;
   logic [7:0] second_port_data;
   logic [7:0] third_port_direction;
   logic [7:0] third_port_data;
   logic [7:0] pinSync1;
   logic [7:0] pinSync2;
   logic [7:0] mismatch;
   logic       change_flag;
   logic       change_irq_enable;
   logic       busOwnsThird;
   logic [7:0] altDrive;
   logic [7:0] altValue;
   logic [7:0] readData;
   logic [7:0] firstPortRead;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------

   // Word index; the two low address bits select bytes only
   assign regIdx    = wbAdr[9:2];
   assign accessReq = wbCyc && wbStb && (busState == BUS_IDLE);
   assign writeReq  = accessReq && wbWe;
   assign readReq   = accessReq && !wbWe;
   // Registers are eight bits, so only lane 0 carries a write
   assign lane0     = wbSel[0];

   // Strobe held past ack starts a second access; the idle
   // state between them is what spaces back-to-back cycles
   // Ack follows one cycle after the request, then drops
   always_comb begin
      next_busState = BUS_IDLE;
      case (busState)
         BUS_IDLE: begin
            if (wbCyc && wbStb) begin
               next_busState = BUS_ACK;
            end
         end
         BUS_ACK: begin
            next_busState = BUS_IDLE;
         end
         default: begin
            next_busState = BUS_IDLE;
         end
      endcase
   end

   // Bus state register
   // One cycle of latency for every access, read or write;
   // no wait states and no error response
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         busState <= BUS_IDLE;
      end else begin
         busState <= next_busState;
      end
   end

   // Handshake output is combinational from the state
   assign wbAck = (busState == BUS_ACK);

   // ----------------------------------------------------------------
   // First port and pull-up control
   // ----------------------------------------------------------------

   // Only bit 7 and the two open-drain latches are writable
   // Other bits are pin levels only; a read-modify-write here
   // copies the pins into the open-drain latches
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pullup_disable_n <= PULLUP_RST;
         firstOdLatch     <= OD_LATCH_RST;
      end else if (writeReq && lane0 &&
                   regIdx == IDX_FIRST_PORT) begin
         pullup_disable_n <= wbDatIn[PULLUP_BIT];
         firstOdLatch     <= wbDatIn[OD_HI_BIT:OD_LO_BIT];
      end
   end

   // Latch one floats the open-drain pin, zero pulls it low
   assign firstOdOe_n = firstOdLatch;

   // Bit 6 is unimplemented and reads zero
   assign firstPortRead = {pullup_disable_n, 1'b0,
                           firstPortIn};

   // ----------------------------------------------------------------
   // Second port registers
   // ----------------------------------------------------------------

   // Direction register, all inputs after reset
   // Load the latch before clearing a direction bit, or the
   // pin drives whatever the latch held until then
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         second_port_direction <= DIR_RST;
      end else if (writeReq && lane0 &&
                   regIdx == IDX_SECOND_DIR) begin
         second_port_direction <= wbDatIn[7:0];
      end
   end

   // Output latch; a write never touches what is read back
   // Reads return the synchronised pins, two cycles behind,
   // so a read-modify-write copies pins, not this latch
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         second_port_data <= LATCH_RST;
      end else if (writeReq && lane0 &&
                   regIdx == IDX_SECOND_DATA) begin
         second_port_data <= wbDatIn[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Second port pins and alternate functions
   // ----------------------------------------------------------------

   // Two-stage synchroniser; only pinSync2 is looked at
   // The first stage may go metastable on a slow key edge,
   // so nothing else may look at it
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pinSync1 <= 8'h00;
         pinSync2 <= 8'h00;
      end else begin
         pinSync1 <= secondPortIn;
         pinSync2 <= pinSync1;
      end
   end

   // Peripherals that drive a pin take it over from the latch
   // The direction bit is left as it was and takes effect again
   // once the peripheral lets go of the pin
   always_comb begin
      altDrive = 8'h00;
      altValue = 8'h00;
      altDrive[PWM_A_BIT]    = pwmOnA;
      altValue[PWM_A_BIT]    = pwm_out_a;
      altDrive[PWM_B_BIT]    = pwmOnB;
      altValue[PWM_B_BIT]    = pwm_out_b;
      altDrive[SPI_CLK_BIT]  = spiClkDrive;
      altValue[SPI_CLK_BIT]  = spiClkOut;
      altDrive[SPI_DATA_BIT] = spiDataDrive;
      altValue[SPI_DATA_BIT] = spiDataOut;
   end

   // Per-pin drive, enable and pull-up
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_second
         assign secondPortOut[gi] = altDrive[gi] ?
                altValue[gi] : second_port_data[gi];
         // Enable low drives; direction one means input
         assign secondPortOe_n[gi] = !altDrive[gi] &&
                second_port_direction[gi];
         // Shared active-low bit, suppressed on outputs and on
         // pins that a peripheral drives, which are outputs too
         assign secondPullupEn[gi] = !pullup_disable_n && !altDrive[gi] &&
                second_port_direction[gi];
         // Pins with direction zero drop out of the comparison; peripheral-driven pins stay in
         assign mismatch[gi] = second_port_direction[gi] &&
                (pinSync2[gi] != second_port_data[gi]);
      end
   endgenerate

   // Input functions see the synchronised pin levels
   // They follow the pin whatever its direction, so an output
   // pin also feeds its own input function
   assign capture_in_a       = pinSync2[CAP_A_BIT];
   assign capture_in_b       = pinSync2[CAP_B_BIT];
   assign timer_ab_ext_clock = pinSync2[TCLK_AB_BIT];
   assign timer_c_ext_clock  = pinSync2[TCLK_C_BIT];
   assign spiClkIn           = pinSync2[SPI_CLK_BIT];

   // ----------------------------------------------------------------
   // Change flag and interrupt
   // ----------------------------------------------------------------

   // Sticky flag, write one to clear. A standing mismatch sets
   // it again at once, so the latch must be rewritten first.
   // The flag starts clear and settles from the comparison.
   // Limitation: a pulse shorter than a clock period can be
   // missed, as the pins are looked at once per cycle.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         change_flag <= FLAG_RST;
      end else if (|mismatch) begin
         change_flag <= 1'b1;
      end else if (writeReq && lane0 &&
                   regIdx == IDX_PERIPH_FLAGS &&
                   wbDatIn[CHANGE_FLAG_BIT]) begin
         change_flag <= 1'b0;
      end
   end

   // Interrupt mask bit
   // Only the change bit lives here; the other enable and
   // flag bits belong to other blocks and read as zero
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         change_irq_enable <= ENABLE_RST;
      end else if (writeReq && lane0 &&
                   regIdx == IDX_PERIPH_ENAB) begin
         change_irq_enable <= wbDatIn[CHANGE_IE_BIT];
      end
   end

   // Comparator runs without any bus access, so wake works
   // while the core sleeps
   // Limitation: core_clk must keep running in sleep, since
   // the synchroniser and the flag are both clocked
   assign irq         = change_flag && change_irq_enable;
   assign wakeRequest = change_flag && change_irq_enable;

   // ----------------------------------------------------------------
   // Third port
   // ----------------------------------------------------------------

   // Microprocessor and extended modes give the pins to the bus
   // Mode is a static strap; changing it at run time hands
   // the pins over with no guard cycle
   assign busOwnsThird = (busMode == MODE_MICROPROC) ||
                         (busMode == MODE_EXT_MCU);

   // Direction register, all inputs after reset
   // Latch and direction keep their values in bus modes and
   // take effect again when the pins return to port use
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         third_port_direction <= DIR_RST;
      end else if (writeReq && lane0 &&
                   regIdx == IDX_THIRD_DIR) begin
         third_port_direction <= wbDatIn[7:0];
      end
   end

   // Output latch
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         third_port_data <= LATCH_RST;
      end else if (writeReq && lane0 &&
                   regIdx == IDX_THIRD_DATA) begin
         third_port_data <= wbDatIn[7:0];
      end
   end

   // Bus controller drives the pins in bus modes
   assign thirdPortOut  = busOwnsThird ?
                          busAdOut : third_port_data;
   assign thirdPortOe_n = busOwnsThird ?
                          {8{!busAdDrive}} :
                          third_port_direction;
   // The bus controller sees the pins in every mode
   assign bus_addr_data_low = thirdPortIn;

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------

   // Unmapped indices read zero and still get an ack
   // Decoded here and registered below: one more flop, but
   // the data output never glitches while the index settles
   always_comb begin
      case (regIdx)
         IDX_FIRST_PORT:   readData = firstPortRead;
         IDX_SECOND_DIR:   readData = second_port_direction;
         IDX_SECOND_DATA:  readData = pinSync2;
         IDX_PERIPH_FLAGS: readData = {change_flag, 7'h00};
         IDX_PERIPH_ENAB:  readData = {change_irq_enable, 7'h00};
         IDX_THIRD_DIR:    readData = third_port_direction;
         IDX_THIRD_DATA:   readData = thirdPortIn;
         default:          readData = 8'h00;
      endcase
   end

   // Data output from a flip-flop, captured with the request
   // Writes leave it alone, so the last read data stays put
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wbDatOut <= 32'h0000_0000;
      end else if (readReq) begin
         wbDatOut <= {24'h00_0000, readData};
      end
   end

endmodule : keypad_port_with_change_irq

// ---- tb.sv ----
// Register-level tests of the keypad port over classic Wishbone.
// Assumes the keypad_pins model and the bound checker.
`timescale 1ns/10ps
module tb
   import keypad_port_pkg::*;
   ;
   logic        core_clk, reset, wbCyc, wbStb, wbWe, wbAck;
   logic        busAdDrive, irq, wakeRequest;
   logic [1:0]  busMode, firstOdOe_n;
   logic [3:0]  wbSel;
   logic [11:0] wbAdr;
   logic [31:0] wbDatIn, wbDatOut;
   logic [5:0]  firstPortIn;
   logic [7:0]  pinsB, outB, oenB, pullB, keyDown, alt, q;
   logic [7:0]  pinsC, outC, oenC, thirdFar, busAdOut;
   int          badCount = 0;
   int          totalChecks = 0;

   keypad_port_with_change_irq dut (
      .core_clk, .reset, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
      .wbDatIn, .wbDatOut, .wbAck, .busMode, .firstPortIn, .firstOdOe_n,
      .secondPortIn(pinsB), .secondPortOut(outB), .secondPortOe_n(oenB),
      .secondPullupEn(pullB), .capture_in_a(), .capture_in_b(),
      .pwm_out_a(alt[0]), .pwmOnA(alt[1]), .pwm_out_b(alt[2]),
      .pwmOnB(alt[3]), .timer_ab_ext_clock(), .timer_c_ext_clock(),
      .spiClkOut(alt[4]), .spiClkDrive(alt[5]), .spiClkIn(),
      .spiDataOut(alt[6]), .spiDataDrive(alt[7]), .thirdPortIn(pinsC),
      .thirdPortOut(outC), .thirdPortOe_n(oenC), .busAdOut, .busAdDrive,
      .bus_addr_data_low(), .irq, .wakeRequest);
   keypad_pins far (.core_clk, .secondPortOut(outB), .secondPortOe_n(oenB),
      .secondPullupEn(pullB), .keyDown, .secondPortIn(pinsB),
      .thirdPortOut(outC), .thirdPortOe_n(oenC), .thirdFar,
      .thirdPortIn(pinsC));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      totalChecks++;
      if (got !== exp) begin
         badCount++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // One classic cycle; waits for ack, never assumes its latency
   task automatic access(input logic we, input logic [7:0] i, d);
      @(posedge core_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= {2'h0, i, 2'h0};
      wbDatIn <= {24'h0, d};
      do begin
         @(posedge core_clk);
      end while (wbAck !== 1'b1);
      check("ack", 8'h01, {7'h0, wbAck});
      q = wbDatOut[7:0];
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : access
   task automatic wr(input logic [7:0] i, d);
      access(1'b1, i, d);
   endtask : wr
   task automatic rd(input string what, input logic [7:0] i, exp);
      access(1'b0, i, 8'h00);
      check(what, exp, q);
   endtask : rd
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   task automatic done(input string t);
      $display("test %s done", t);
   endtask : done
   task automatic wrapUp;
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrapUp

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      {reset, wbCyc, wbStb, wbWe, busAdDrive} = 5'b10000;
      wbSel = 4'hF;
      wbAdr = 12'h000;
      wbDatIn = 32'h0;
      busMode = 2'h2;
      alt = 8'h00;
      keyDown = 8'h00;
      firstPortIn = 6'h2A;
      thirdFar = 8'h5A;
      busAdOut = 8'h3C;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      tick(1);
      check("pullups", 8'hFF, pullB);
      check("od enables", 8'h03, {6'h0, firstOdOe_n});
      rd("direction", IDX_SECOND_DIR, 8'hFF);
      rd("enables", IDX_PERIPH_ENAB, 8'h00);
      rd("first port", IDX_FIRST_PORT, 8'h2A);
      rd("flags", IDX_PERIPH_FLAGS, 8'h80);
      wr(IDX_PERIPH_FLAGS, 8'h80);
      rd("flags", IDX_PERIPH_FLAGS, 8'h80);
      rd("data", IDX_SECOND_DATA, 8'hFF);
      wr(IDX_SECOND_DATA, q);
      wr(IDX_PERIPH_FLAGS, 8'h80);
      rd("flags", IDX_PERIPH_FLAGS, 8'h00);
      done("reset and clear");
      wr(IDX_PERIPH_ENAB, 8'h80);
      keyDown <= 8'h01;
      tick(5);
      check("irq", 8'h01, {7'h0, irq});
      check("wake", 8'h01, {7'h0, wakeRequest});
      wr(IDX_PERIPH_ENAB, 8'h00);
      check("irq masked", 8'h00, {7'h0, irq});
      rd("data", IDX_SECOND_DATA, 8'hFE);
      keyDown <= 8'h00;
      tick(4);
      wr(IDX_SECOND_DATA, 8'hFF);
      wr(IDX_PERIPH_FLAGS, 8'h80);
      rd("flags", IDX_PERIPH_FLAGS, 8'h00);
      done("change interrupt");
      wr(IDX_SECOND_DIR, 8'hFE);
      check("oe", 8'hFE, oenB);
      check("pullups", 8'hFE, pullB);
      keyDown <= 8'h01;
      tick(5);
      rd("flags", IDX_PERIPH_FLAGS, 8'h00);
      keyDown <= 8'h00;
      wr(IDX_SECOND_DIR, 8'hFF);
      wr(IDX_FIRST_PORT, 8'h8C);
      check("pullups off", 8'h00, pullB);
      rd("first port", IDX_FIRST_PORT, 8'hAA);
      wr(IDX_FIRST_PORT, 8'h0C);
      tick(4);
      wr(IDX_PERIPH_FLAGS, 8'h80);
      rd("flags", IDX_PERIPH_FLAGS, 8'h00);
      done("outputs and pull-ups");
      alt <= 8'hAA;
      tick(1);
      check("alt oe", 8'h00, oenB & 8'hCC);
      check("alt out", 8'h00, outB & 8'hCC);
      check("alt pullups", 8'h00, pullB & 8'hCC);
      alt <= 8'h00;
      wr(IDX_THIRD_DIR, 8'h0F);
      wr(IDX_THIRD_DATA, 8'hA5);
      check("third oe", 8'h0F, oenC);
      rd("third data", IDX_THIRD_DATA, 8'hAA);
      busAdDrive <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         busMode <= m[1:0];
         tick(1);
         check("mode oe", (m < 2) ? 8'h00 : 8'h0F, oenC);
      end
      busMode <= 2'h2;
      busAdDrive <= 1'b0;
      wr(8'h05, 8'hFF);
      rd("unmapped", 8'h05, 8'h00);
      done("alternate and third port");
      wrapUp();
   end
   // Whole sequence needs well under 1000 cycles
   initial begin
      #500000;
      badCount++;
      wrapUp();
   end
endmodule : tb
